// ---- common/flrb_defs.vh ----
// constants for the fuse and lock readback and self-programming control block
`ifndef FLRB_DEFS_VH
`define FLRB_DEFS_VH

// -------------------------------------------------------------
// readback pointer values
// -------------------------------------------------------------
`define FLRB_PTR_FUSE_LOW   16'h0000
`define FLRB_PTR_LOCK       16'h0001
`define FLRB_PTR_FUSE_EXT   16'h0002
`define FLRB_PTR_FUSE_HIGH  16'h0003

// -------------------------------------------------------------
// control register field positions and command codes
// -------------------------------------------------------------
`define FLRB_CTL_SELF_PROG  0
`define FLRB_CTL_PAGE_ERASE 1
`define FLRB_CTL_PAGE_WRITE 2
`define FLRB_CTL_LOCK_SET   3
`define FLRB_CTL_RWW_REEN   4
`define FLRB_CMD_MASK       5'h1F
`define FLRB_CMD_ERASE      5'h03
`define FLRB_CMD_WRITE      5'h05
`define FLRB_CMD_LOCK       5'h09
`define FLRB_CMD_REEN       5'h11

// -------------------------------------------------------------
// windows and field masks
// -------------------------------------------------------------
`define FLRB_LOAD_WINDOW    3'h3
`define FLRB_STORE_WINDOW   3'h4
`define FLRB_EXT_MASK       8'h0F
`define FLRB_EXT_UNUSED     8'hF0
`define FLRB_LOCK_KEEP      8'hC3
`define FLRB_BOOT_LOCK_BIT  4

// -------------------------------------------------------------
// flash write timing on the rc oscillator tick
// -------------------------------------------------------------
`define FLRB_RC_TICK_NS     1000
`define FLRB_WRITE_MIN_US   3700
`define FLRB_WRITE_MAX_US   4500
`define FLRB_WRITE_TICKS    ((`FLRB_WRITE_MIN_US * 1000 + `FLRB_RC_TICK_NS - 1) / `FLRB_RC_TICK_NS)
`define FLRB_NO_READ_WHILE_WRITE_SECTION_START     16'h0C00

`endif

// ---- core/flrb_window.v ----
// one countdown window that expires when its action does not arrive
`timescale 1ns/10ps
`default_nettype none

module flrb_window #(
  parameter [2:0] LEN = 3'h3
) (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       start_in,
  input  wire       stop_in,
  output reg        open_out,
  output reg        expire_out
);

  reg [2:0] count;

  // --------------------------------------------------------------
  // countdown
  // --------------------------------------------------------------
  // count starts the cycle after the arming write, only cpu cycles count
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count      <= 3'h0;
      open_out   <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= 1'b0;
      if (start_in) begin
        count    <= LEN;
        open_out <= 1'b1;
      end else if (stop_in) begin
        count    <= 3'h0;
        open_out <= 1'b0;
      end else if (open_out) begin
        if (count == 3'h1) begin
          open_out   <= 1'b0;
          expire_out <= 1'b1;
        end
        count <= count - 3'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- core/flrb_core.v ----
// fuse and lock readback with self-programming sequencing and timing
`timescale 1ns/10ps
`default_nettype none
`include "flrb_defs.vh"

module flrb_core (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        ctl_write_in,
  input  wire [7:0]  ctl_data_in,
  input  wire        load_in,
  input  wire        store_in,
  input  wire [15:0] ptr_in,
  input  wire [7:0]  store_data_in,
  input  wire [7:0]  pmem_data_in,
  input  wire        eeprom_write_busy_in,
  input  wire        rc_tick_in,
  input  wire [7:0]  fuse_low_byte_in,
  input  wire [7:0]  fuse_high_byte_in,
  input  wire [3:0]  extended_fuse_byte_in,
  input  wire [7:0]  lock_bits_in,
  input  wire        fetch_in,
  input  wire [15:0] fetch_addr_in,
  output reg  [7:0]  load_data_out,
  output reg         load_valid_out,
  output reg         self_prog_enable_out,
  output reg         lock_bit_set_flag_out,
  output reg         rww_busy_out,
  output reg         flash_busy_out,
  output reg         flash_erase_out,
  output reg         flash_write_out,
  output reg         lock_write_out,
  output reg  [7:0]  lock_write_data_out,
  output reg  [15:0] flash_addr_out,
  output reg         fetch_stall_out,
  output reg         refused_out
);

  // --------------------------------------------------------------
  // states of the flash operation
  // --------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ERASE = 2'h1;
  localparam [1:0] ST_WRITE = 2'h2;
  localparam [1:0] ST_LOCK  = 2'h3;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [15:0] ticks;
  reg         armed_read;
  reg  [4:0]  cmd;
  wire        load_open;
  wire        load_expire;
  wire        store_open;
  wire        store_expire;
  wire        ctl_ok;
  wire        arm_read;
  wire        arm_store;
  wire        readback;
  wire        boot_locked;
  wire        store_go;
  wire        op_done;
  wire        in_boot;
  reg  [7:0]  next_data;
  wire [31:0] write_ticks_full;

  // write length is an integer expression; only the low half is ever used
  assign write_ticks_full = `FLRB_WRITE_TICKS;

  // --------------------------------------------------------------
  // arming
  // --------------------------------------------------------------
  // eeprom write blocks any arming of readback or programming
  assign ctl_ok    = ctl_write_in && !eeprom_write_busy_in && state == ST_IDLE;
  assign arm_read  = ctl_ok &&
                     (ctl_data_in[4:0] & `FLRB_CMD_MASK) == `FLRB_CMD_LOCK;
  assign arm_store = ctl_ok && ctl_data_in[`FLRB_CTL_SELF_PROG];
  assign readback  = load_in && load_open && armed_read &&
                     !eeprom_write_busy_in;
  assign in_boot   = ptr_in[15:1] >= `FLRB_NO_READ_WHILE_WRITE_SECTION_START;
  // programmed boot lock bit reads zero; zero forbids boot updates
  assign boot_locked = !lock_bits_in[`FLRB_BOOT_LOCK_BIT];
  assign store_go  = store_in && store_open && !eeprom_write_busy_in;
  assign op_done   = rc_tick_in && ticks == 16'h0001;

  // load window of three cycles, store window of four
  flrb_window #(
    .LEN (`FLRB_LOAD_WINDOW)
  ) u_load_win (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .start_in   (arm_read),
    .stop_in    (readback | store_go),
    .open_out   (load_open),
    .expire_out (load_expire)
  );

  flrb_window #(
    .LEN (`FLRB_STORE_WINDOW)
  ) u_store_win (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .start_in   (arm_store),
    .stop_in    (store_go),
    .open_out   (store_open),
    .expire_out (store_expire)
  );

  // --------------------------------------------------------------
  // control flags and auto-clear
  // --------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed_read            <= 1'b0;
      cmd                   <= 5'h00;
      self_prog_enable_out  <= 1'b0;
      lock_bit_set_flag_out <= 1'b0;
    end else if (ctl_ok) begin
      armed_read            <= arm_read;
      cmd                   <= ctl_data_in[4:0];
      self_prog_enable_out  <= ctl_data_in[`FLRB_CTL_SELF_PROG];
      lock_bit_set_flag_out <= ctl_data_in[`FLRB_CTL_LOCK_SET];
    end else if (readback || load_expire || store_expire) begin
      armed_read            <= 1'b0;
      lock_bit_set_flag_out <= 1'b0;
      self_prog_enable_out  <= 1'b0;
    end else if (store_go) begin
      // enable stays up through a started operation; a refused one drops it
      armed_read            <= 1'b0;
      self_prog_enable_out  <= next_state != ST_IDLE;
      lock_bit_set_flag_out <= next_state == ST_LOCK;
    end else if (op_done) begin
      self_prog_enable_out  <= 1'b0;
      lock_bit_set_flag_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // load data path
  // --------------------------------------------------------------
  // stored bits are already active-low: programmed reads zero
  always @* begin
    next_data = pmem_data_in;
    if (readback) begin
      case (ptr_in)
        `FLRB_PTR_FUSE_LOW:  next_data = fuse_low_byte_in;
        `FLRB_PTR_LOCK:      next_data = lock_bits_in;
        `FLRB_PTR_FUSE_EXT:  next_data = {4'hF, extended_fuse_byte_in};
        `FLRB_PTR_FUSE_HIGH: next_data = fuse_high_byte_in;
        default:             next_data = pmem_data_in;
      endcase
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_data_out  <= 8'h00;
      load_valid_out <= 1'b0;
    end else begin
      load_valid_out <= load_in;
      if (load_in) begin
        load_data_out <= next_data;
      end
    end
  end

  // --------------------------------------------------------------
  // flash operation sequencer
  // --------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (store_go) begin
          if (cmd == `FLRB_CMD_ERASE || cmd == `FLRB_CMD_WRITE) begin
            if (in_boot && boot_locked) begin
              next_state = ST_IDLE;
            end else if (cmd == `FLRB_CMD_ERASE) begin
              next_state = ST_ERASE;
            end else begin
              next_state = ST_WRITE;
            end
          end else if (cmd == `FLRB_CMD_LOCK) begin
            next_state = ST_LOCK;
          end
        end
      end
      ST_ERASE, ST_WRITE, ST_LOCK: begin
        if (op_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // the sequencer sits outside the cpu reset so an active write
  // completes; only a cleared sequencer accepts a start
  always @(posedge clk_in) begin
    state <= next_state;
    if (state == ST_IDLE && next_state != ST_IDLE) begin
      ticks <= write_ticks_full[15:0];
    end else if (state != ST_IDLE && rc_tick_in) begin
      ticks <= ticks - 16'h0001;
    end
  end

  // --------------------------------------------------------------
  // flash strobes, section blocking and status
  // --------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flash_busy_out      <= 1'b0;
      flash_erase_out     <= 1'b0;
      flash_write_out     <= 1'b0;
      lock_write_out      <= 1'b0;
      lock_write_data_out <= 8'hFF;
      flash_addr_out      <= 16'h0000;
      fetch_stall_out     <= 1'b0;
      rww_busy_out        <= 1'b0;
      refused_out         <= 1'b0;
    end else begin
      flash_busy_out  <= next_state != ST_IDLE;
      flash_erase_out <= next_state == ST_ERASE;
      flash_write_out <= next_state == ST_WRITE;
      lock_write_out  <= next_state == ST_LOCK;
      refused_out     <= state == ST_IDLE && store_go && in_boot && boot_locked &&
                         (cmd == `FLRB_CMD_ERASE || cmd == `FLRB_CMD_WRITE);
      if (state == ST_IDLE && next_state != ST_IDLE) begin
        flash_addr_out      <= ptr_in;
        lock_write_data_out <= store_data_in | `FLRB_LOCK_KEEP;
      end
      // read-while-write section unreadable until re-enabled
      if (next_state == ST_ERASE || next_state == ST_WRITE) begin
        rww_busy_out <= 1'b1;
      end else if (state == ST_IDLE && store_go && cmd == `FLRB_CMD_REEN) begin
        rww_busy_out <= 1'b0;
      end
      fetch_stall_out <= fetch_in && rww_busy_out &&
                         fetch_addr_in < `FLRB_NO_READ_WHILE_WRITE_SECTION_START;
    end
  end

endmodule

`default_nettype wire

// ---- verification/flrb_core_assertions.sv ----
// concurrent checks on the readback and self-programming ports
`timescale 1ns/10ps
`default_nettype none
module flrb_core_checker (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        load_in,
  input wire logic        store_in,
  input wire logic [15:0] ptr_in,
  input wire logic [7:0]  pmem_data_in,
  input wire logic        eeprom_write_busy_in,
  input wire logic [7:0]  fuse_low_byte_in,
  input wire logic [7:0]  fuse_high_byte_in,
  input wire logic [3:0]  extended_fuse_byte_in,
  input wire logic [7:0]  lock_bits_in,
  input wire logic        fetch_in,
  input wire logic [15:0] fetch_addr_in,
  input wire logic [7:0]  load_data_out,
  input wire logic        load_valid_out,
  input wire logic        self_prog_enable_out,
  input wire logic        lock_bit_set_flag_out,
  input wire logic        rww_busy_out,
  input wire logic        fetch_stall_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // cycles the lock flag has stood; a load on the fourth is too late
  logic [1:0] flag_age;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_age <= 2'h0;
    end else if (!lock_bit_set_flag_out) begin
      flag_age <= 2'h0;
    end else if (flag_age != 2'h3) begin
      flag_age <= flag_age + 2'h1;
    end
  end
  // helper terms shared by several checks
  wire armed = lock_bit_set_flag_out & self_prog_enable_out & load_in &
               ~eeprom_write_busy_in & (flag_age != 2'h3);
  wire plain = ~lock_bit_set_flag_out & ~self_prog_enable_out & load_in;
  wire idle  = ~load_in & ~store_in;
  wire stall_due = rww_busy_out & (fetch_addr_in < 16'h0C00);
  chk_load_answer: assert property (load_in |=> load_valid_out)
    else $error("load gave no answer");
  chk_lock_read: assert property (armed && ptr_in == 16'h0001
    |=> load_data_out == $past(lock_bits_in)) else $error("lock byte wrong");
  chk_fuse_low: assert property (armed && ptr_in == 16'h0000
    |=> load_data_out == $past(fuse_low_byte_in)) else $error("fuse low wrong");
  chk_fuse_high: assert property (armed && ptr_in == 16'h0003
    |=> load_data_out == $past(fuse_high_byte_in)) else $error("fuse high wrong");
  chk_fuse_ext: assert property (armed && ptr_in == 16'h0002
    |=> load_data_out == {4'hF, $past(extended_fuse_byte_in)}) else $error("fuse ext wrong");
  chk_flags_done: assert property (armed
    |=> !lock_bit_set_flag_out && !self_prog_enable_out) else $error("flags kept");
  chk_window_lapse: assert property ($rose(lock_bit_set_flag_out) && idle ##1 idle [*2]
    |-> ##2 !lock_bit_set_flag_out && !self_prog_enable_out) else $error("window kept");
  chk_plain_load: assert property (plain
    |=> load_data_out == $past(pmem_data_in)) else $error("plain load wrong");
  chk_eeprom_block: assert property (eeprom_write_busy_in && load_in
    |=> load_data_out == $past(pmem_data_in)) else $error("readback while busy");
  chk_fetch_stall: assert property (fetch_in
    |=> fetch_stall_out == $past(stall_due)) else $error("fetch stall wrong");
endmodule
bind flrb_core flrb_core_checker i_chk (
  .clk_in                (clk_in),
  .rst_in                (rst_in),
  .load_in               (load_in),
  .store_in              (store_in),
  .ptr_in                (ptr_in),
  .pmem_data_in          (pmem_data_in),
  .eeprom_write_busy_in  (eeprom_write_busy_in),
  .fuse_low_byte_in      (fuse_low_byte_in),
  .fuse_high_byte_in     (fuse_high_byte_in),
  .extended_fuse_byte_in (extended_fuse_byte_in),
  .lock_bits_in          (lock_bits_in),
  .fetch_in              (fetch_in),
  .fetch_addr_in         (fetch_addr_in),
  .load_data_out         (load_data_out),
  .load_valid_out        (load_valid_out),
  .self_prog_enable_out  (self_prog_enable_out),
  .lock_bit_set_flag_out (lock_bit_set_flag_out),
  .rww_busy_out          (rww_busy_out),
  .fetch_stall_out       (fetch_stall_out)
);
`default_nettype wire

// ---- verification/flrb_nvm_model.sv ----
// nonvolatile array model: raw fuse, lock and program bytes plus rc tick
`timescale 1ns/10ps
`default_nettype none
module flrb_nvm_model #(
  parameter logic [7:0] FLO = 8'hA5,
  parameter logic [7:0] FHI = 8'h3C,
  parameter logic [3:0] FEX = 4'h6,
  parameter logic [7:0] LCK = 8'hEF
) (
  input  wire logic        clk_in,
  input  wire logic [15:0] ptr_in,
  output logic      [7:0]  pmem_out,
  output logic      [7:0]  flo_out,
  output logic      [7:0]  fhi_out,
  output logic      [3:0]  fex_out,
  output logic      [7:0]  lck_out,
  output logic             tick_out
);
  // stored cells, a programmed bit is held as zero
  assign flo_out = FLO;
  assign fhi_out = FHI;
  assign fex_out = FEX;
  assign lck_out = LCK;
  // bytes differ per address so a stale answer shows
  assign pmem_out = ptr_in[7:0] ^ 8'h5A;
  // tick at half the cpu rate keeps write times short
  initial tick_out = 1'b0;
  always @(posedge clk_in) tick_out <= ~tick_out;
endmodule
`default_nettype wire

// ---- verification/flrb_core_tb.sv ----
// self-checking bench for the fuse and lock readback block
`timescale 1ns/10ps
`default_nettype none
module flrb_core_tb;
  localparam logic [7:0] FLO = 8'hA5, FHI = 8'h3C, LCK = 8'hEF;
  localparam logic [3:0] FEX = 4'h6;
  logic clk_in = 1'b0, rst_in = 1'b1, ctl_write_in = 1'b0, load_in = 1'b0;
  logic store_in = 1'b0, eeprom_write_busy_in = 1'b0, fetch_in = 1'b0;
  logic [7:0] ctl_data_in = 8'h00, store_data_in = 8'h00;
  logic [15:0] ptr_in = 16'h0000, fetch_addr_in = 16'h0000;
  wire [7:0] pmem, flo, fhi, lck, ld_data, lw_data;
  wire [3:0] fex;
  wire tick, ld_valid, spe, lbs, read_while_write_section, busy, ers, wrt, lwr, stall, refused;
  int fails = 0, cmp_count = 0, seed = 22186, i, n, d;
  logic [15:0] p;
  always #5 clk_in = ~clk_in;
  flrb_nvm_model #(.FLO(FLO), .FHI(FHI), .FEX(FEX), .LCK(LCK)) i_nvm (.clk_in(clk_in),
    .ptr_in(ptr_in), .pmem_out(pmem), .flo_out(flo), .fhi_out(fhi), .fex_out(fex),
    .lck_out(lck), .tick_out(tick));
  flrb_core i_dut (.clk_in(clk_in), .rst_in(rst_in), .ctl_write_in(ctl_write_in),
    .ctl_data_in(ctl_data_in), .load_in(load_in), .store_in(store_in), .ptr_in(ptr_in),
    .store_data_in(store_data_in), .pmem_data_in(pmem),
    .eeprom_write_busy_in(eeprom_write_busy_in), .rc_tick_in(tick), .fuse_low_byte_in(flo),
    .fuse_high_byte_in(fhi), .extended_fuse_byte_in(fex), .lock_bits_in(lck),
    .fetch_in(fetch_in), .fetch_addr_in(fetch_addr_in), .load_data_out(ld_data),
    .load_valid_out(ld_valid), .self_prog_enable_out(spe), .lock_bit_set_flag_out(lbs),
    .rww_busy_out(read_while_write_section), .flash_busy_out(busy), .flash_erase_out(ers),
    .flash_write_out(wrt), .lock_write_out(lwr), .lock_write_data_out(lw_data),
    .flash_addr_out(), .fetch_stall_out(stall), .refused_out(refused));
  // expected load answer; late or unarmed loads see program bytes
  function automatic logic [7:0] exp_rb(input logic [15:0] a, input int dl, input logic arm);
    if (!arm || dl > 3) return a[7:0] ^ 8'h5A;
    case (a)
      16'h0000: return FLO;
      16'h0001: return LCK;
      16'h0002: return {4'hF, FEX};
      default:  return FHI;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // arm readback, then load dl cycles after the control write
  task automatic rb(input logic [15:0] a, input int dl, input logic arm);
    @(posedge clk_in);
    ctl_write_in <= arm;
    ctl_data_in  <= 8'h09;
    @(posedge clk_in);
    ctl_write_in <= 1'b0;
    repeat (dl - 1) @(posedge clk_in);
    load_in <= 1'b1;
    ptr_in  <= a;
    @(posedge clk_in);
    load_in <= 1'b0;
    #1;
    chk("load_valid", 8'h01, {7'h0, ld_valid});
    chk("load_data", exp_rb(a, dl, arm & ~eeprom_write_busy_in), ld_data);
    chk("flags", 8'h00, {6'h0, spe, lbs});
  endtask
  // control write followed by a store in the next cycle
  task automatic sp(input logic [7:0] c, input logic [15:0] a);
    @(posedge clk_in);
    ctl_write_in <= 1'b1;
    ctl_data_in  <= c;
    @(posedge clk_in);
    ctl_write_in <= 1'b0;
    store_in     <= 1'b1;
    ptr_in       <= a;
    @(posedge clk_in);
    store_in <= 1'b0;
    #1;
  endtask
  // bounded wait for the running operation to end
  task automatic wait_idle;
    n = 0;
    while (busy !== 1'b0 || lwr !== 1'b0) begin
      @(posedge clk_in);
      n++;
      if (n > 20000) begin
        fails++;
        conclude();
      end
    end
  endtask
  initial begin
    // no control writes while the core is held in reset
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 4; i++) rb(i[15:0], 3, 1'b1);
    for (i = 0; i < 24; i++) begin
      p = $random(seed);
      d = 1 + ({$random(seed)} % 4);
      rb({14'h0, p[1:0]}, d, 1'b1);
    end
    rb(16'h0003, 1, 1'b0);
    @(posedge clk_in);
    eeprom_write_busy_in <= 1'b1;
    rb(16'h0001, 1, 1'b1);
    @(posedge clk_in);
    eeprom_write_busy_in <= 1'b0;
    $display("readback tests done");
    // erase then page write in the application section, fetches meanwhile
    for (i = 0; i < 2; i++) begin
      sp(i ? 8'h05 : 8'h03, 16'h0100);
      @(posedge clk_in);
      fetch_in      <= 1'b1;
      fetch_addr_in <= 16'h0010;
      #1;
      chk("operation", 8'h01, {7'h0, i ? wrt : ers});
      @(posedge clk_in);
      fetch_addr_in <= 16'h0C10;
      #1;
      chk("stall_rww", 8'h01, {7'h0, stall});
      @(posedge clk_in);
      fetch_in <= 1'b0;
      #1;
      chk("stall_no_read_while_write_section", 8'h00, {7'h0, stall});
      wait_idle();
      chk("write_time", 8'h01, {7'h0, n >= 2 * 3700 - 8 && n <= 2 * 4500});
      chk("rww_held", 8'h01, {7'h0, read_while_write_section});
      sp(8'h11, 16'h0000);
      @(posedge clk_in);
      #1;
      chk("rww_free", 8'h00, {7'h0, read_while_write_section});
    end
    // lock write keeps the fixed bits set
    @(posedge clk_in);
    store_data_in <= $random(seed);
    sp(8'h09, 16'h0001);
    @(posedge clk_in);
    #1;
    chk("lock_data", store_data_in | 8'hC3, lw_data);
    chk("lock_write", 8'h01, {7'h0, lwr});
    wait_idle();
    // boot section locked: update refused
    sp(8'h03, 16'h1800); // byte pointer of boot word 0x0C00
    d = refused;
    repeat (4) begin
      @(posedge clk_in);
      #1;
      d = d | refused;
    end
    chk("refused", 8'h01, {7'h0, d[0]});
    chk("no_erase", 8'h00, {7'h0, busy});
    $display("programming tests done");
    conclude();
  end
endmodule
`default_nettype wire
